// file: design/ccs_pkg.sv
// How it works
// - Above weak threshold: constant current, code 010
// - Termination voltage reached: switch to constant voltage
// - Fast charge timeout before termination: fault
// - Timeout after termination: stop, no fault
// - Watchdog starts on first kick or weak
// - Watchdog expiry while charging starts safety timer
// - Safety timer start restores default current cap
// - Safety timer expiry stops charging, updates state
// - Current below end for qualify time: done
// - Current rising above end restarts qualify timer
// - Recharge threshold after done restarts constant voltage
// - Recharge disable still flags recharge needed
// - Chip disable by pin or bit stops charging, timers, lamp and grant; the regulator follows the pin only
// - Charging off keeps regulator, voltage selectable
// - Host charging bit write overrides enable pin
// - Hold-off blocks start above threshold
// - Hold-off disabled after reset, bit enables
// - Mode 00: grant when chip enabled, system up
// - Mode 01: grant follows battery node, charging
// - Mode 10: no supply, monitor on, below weak
// - Mode 11: chip enabled when charging disabled, else charging and above weak
// - Lamp: off, on, 167/833 ms, 1/1 s
// - Fault code 110, cleared by write or power cycle
package ccs_pkg;
   // Charge state field codes
   localparam logic [2:0] CCS_ST_OFF   = 3'h0;
   localparam logic [2:0] CCS_ST_CC    = 3'h2;
   localparam logic [2:0] CCS_ST_CV    = 3'h3;
   localparam logic [2:0] CCS_ST_DONE  = 3'h4;
   localparam logic [2:0] CCS_ST_FAULT = 3'h6;
   // System power grant modes
   localparam logic [1:0] CCS_SG_LDO   = 2'h0;
   localparam logic [1:0] CCS_SG_BAT   = 2'h1;
   localparam logic [1:0] CCS_SG_MON   = 2'h2;
   localparam logic [1:0] CCS_SG_MIX   = 2'h3;
   // Lamp patterns
   localparam logic [1:0] CCS_LP_OFF   = 2'h0;
   localparam logic [1:0] CCS_LP_ON    = 2'h1;
   localparam logic [1:0] CCS_LP_SHORT = 2'h2;
   localparam logic [1:0] CCS_LP_SLOW  = 2'h3;
   // Reset value of the input current cap (default setting)
   localparam logic [3:0] CCS_CAP_DEFAULT = 4'h0;
   // Clock and slow tick
   localparam int CCS_CLK_HZ      = 100_000_000;
   localparam int CCS_TICK_US     = 1000;
   localparam int CCS_TICK_CYC    = CCS_CLK_HZ / 1_000_000 * CCS_TICK_US;
   // Lamp timing in ms, as counts of 1 ms ticks
   localparam int CCS_BLINK_ON_MS  = 167;
   localparam int CCS_BLINK_OFF_MS = 833;
   localparam int CCS_SLOW_ON_MS   = 1000;
   localparam int CCS_SLOW_OFF_MS  = 1000;
   // Timer durations in ms (plain defaults)
   localparam int CCS_FAST_MS  = 600_000;
   localparam int CCS_WDOG_MS  = 32_000;
   localparam int CCS_SAFE_MS  = 2_400_000;
   localparam int CCS_END_MS   = 30_000;

   // Charge sequencer states
   typedef enum logic [2:0] {
      CCS_IDLE  = 3'b000,
      CCS_CC    = 3'b001,
      CCS_CV    = 3'b010,
      CCS_DONE  = 3'b011,
      CCS_STOP  = 3'b100,
      CCS_FAULT = 3'b101
   } ccs_state_e;

   // Comparator inputs from the analog side
   typedef struct packed {
      logic above_dead;
      logic above_weak;
      logic at_term;
      logic below_end;
      logic below_rch;
      logic above_holdoff;
      logic supply_ok;
      logic sys_ok;
   } ccs_cmp_s;

   // Host configuration
   typedef struct packed {
      logic       chip_en;
      logic       charging_allowed;
      logic       charging_allowed_wr;
      logic       high_battery_holdoff_en;
      logic       recharge_en;
      logic       battery_monitor_on;
      logic       watchdog_kick;
      logic       fault_clear;
      logic       cap_wr;
      logic [3:0] cap_value;
      logic       sysv_sel;
      logic [1:0] grant_mode;
      logic [1:0] lamp_mode;
   } ccs_cfg_s;
endpackage

// file: design/ccs_sequencer.sv
// Charge cycle sequencer top
module ccs_sequencer import ccs_pkg::*; #(
   parameter int FAST_MS = CCS_FAST_MS,
   parameter int WDOG_MS = CCS_WDOG_MS,
   parameter int SAFE_MS = CCS_SAFE_MS,
   parameter int END_MS  = CCS_END_MS,
   parameter int TICK_CYC = CCS_TICK_CYC
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // Analog comparators and pins (asynchronous)
   input  wire ccs_cmp_s   cmp_i,
   input  wire logic       option_pin_two_i,
   input  wire logic       option_pin_three_i,
   // Host configuration (same clock)
   input  wire ccs_cfg_s   cfg_i,
   // Charger controls
   output logic            charge_on_o,
   output logic            cv_mode_o,
   output logic            regulator_on_o,
   output logic            sysv_sel_o,
   output logic [3:0]      input_current_cap_o,
   output logic            iso_switch_off_o,
   // Status
   output logic [2:0]      charge_state_o,
   output logic            charge_done_flag_o,
   output logic            recharge_needed_o,
   output logic            holdoff_en_o,
   // Open-drain outputs
   output logic            system_power_grant_o,
   output logic            system_power_grant_oe_o,
   output logic            indicator_lamp_out_o,
   output logic            indicator_lamp_out_oe_o
);
   // Whole module state
   typedef struct packed {
      ccs_cmp_s   cmp_m;       // First synchroniser stage
      ccs_cmp_s   cmp;         // Synchronised comparators
      logic [1:0] pin2_m;      // Option pins, first stage
      logic [1:0] pins;        // Option pins, synchronised
      ccs_state_e st;
      logic [2:0] code;
      logic       host_en_set; // Host has written the charging bit
      logic       host_en;
      logic       holdoff;
      logic       wd_run;
      logic       term_seen;
      logic       safe_run;
      logic       cap_host;    // Host programmed the cap
      logic [3:0] cap;
      logic       done;
      logic       rch_need;
      logic [31:0] div;
      logic       tick;
      logic [10:0] lamp_ms;
      logic       grant;
      logic       lamp;
      logic       iso_off;
      // Registered copies of decoded outputs
      logic       chg;
      logic       cv;
      logic       reg_on;
      logic       sysv;
   } ccs_top_s;

   ccs_top_s r;       // Registered state
   ccs_top_s next_r;  // Next state

   // Timer expiry pulses
   logic fast_exp;
   logic wd_exp;
   logic safe_exp;
   logic end_exp;
   // Timer run enables
   logic fast_run;
   logic end_run;
   logic charging;
   logic en_eff;
   logic chip_on;

   // Timer limits as tick counts; one tick is 1 ms
   localparam logic [31:0] FAST_T = 32'(FAST_MS);
   localparam logic [31:0] WDOG_T = 32'(WDOG_MS);
   localparam logic [31:0] SAFE_T = 32'(SAFE_MS);
   localparam logic [31:0] END_T  = 32'(END_MS);

   // Derived enables
   always_comb begin
      charging = (r.st == CCS_CC) || (r.st == CCS_CV);
      // Host write overrides pin level
      en_eff   = r.host_en_set ? r.host_en : r.pins[1];
      // Pin or bit disable
      chip_on  = cfg_i.chip_en && !r.pins[0];
      fast_run = charging && chip_on;
      end_run  = (r.st == CCS_CV) && r.cmp.below_end && chip_on;
   end

   // Fast charge timer
   ccs_timer #(.W(32)) u_fast (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .tick_i    (r.tick),
      .run_i     (fast_run),
      .clr_i     (1'b0),
      .limit_i   (FAST_T),
      .expired_o (fast_exp)
   );

   // Watchdog; each kick restarts it
   ccs_timer #(.W(32)) u_wdog (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .tick_i    (r.tick),
      .run_i     (r.wd_run && chip_on),
      .clr_i     (cfg_i.watchdog_kick),
      .limit_i   (WDOG_T),
      .expired_o (wd_exp)
   );

   // Safety timer
   ccs_timer #(.W(32)) u_safe (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .tick_i    (r.tick),
      .run_i     (r.safe_run && chip_on),
      .clr_i     (1'b0),
      .limit_i   (SAFE_T),
      .expired_o (safe_exp)
   );

   // End qualification; leaving below_end clears it
   ccs_timer #(.W(32)) u_end (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .tick_i    (r.tick),
      .run_i     (end_run),
      .clr_i     (1'b0),
      .limit_i   (END_T),
      .expired_o (end_exp)
   );

   // Next state
   always_comb begin
      next_r = r;
      // Two flop synchronisers on asynchronous inputs
      next_r.cmp_m  = cmp_i;
      next_r.cmp    = r.cmp_m;
      next_r.pin2_m = {option_pin_three_i, option_pin_two_i};
      next_r.pins   = r.pin2_m;

      // Common slow tick
      if (r.div >= 32'(TICK_CYC - 1)) begin
         next_r.div  = '0;
         next_r.tick = 1'b1;
      end else begin
         next_r.div  = r.div + 32'h0000_0001;
         next_r.tick = 1'b0;
      end

      // Host configuration bits
      if (cfg_i.charging_allowed_wr) begin
         next_r.host_en_set = 1'b1;
         next_r.host_en     = cfg_i.charging_allowed;
      end
      // Hold-off bit, clear after reset
      next_r.holdoff = cfg_i.high_battery_holdoff_en;
      if (cfg_i.cap_wr) begin
         next_r.cap      = cfg_i.cap_value;
         next_r.cap_host = 1'b1;
      end

      // Watchdog start on first kick or weak
      if (cfg_i.watchdog_kick || r.cmp.above_weak) begin
         next_r.wd_run = 1'b1;
      end
      // Expiry while charging starts safety timer
      if (wd_exp && charging && !r.safe_run) begin
         next_r.safe_run = 1'b1;
         if (r.cap_host) begin
            next_r.cap = CCS_CAP_DEFAULT;
         end
      end

      // Recharge needed flag
      if (r.st == CCS_DONE && r.cmp.below_rch) begin
         next_r.rch_need = !cfg_i.recharge_en;
      end else if (r.st != CCS_DONE) begin
         next_r.rch_need = 1'b0;
      end

      // Charge sequence
      case (r.st)
         CCS_IDLE: begin
            next_r.code = CCS_ST_OFF;
            // Hold-off blocks start above threshold
            if (en_eff && r.cmp.above_dead && r.cmp.above_weak
                && !(r.holdoff && r.cmp.above_holdoff)) begin
               next_r.st        = CCS_CC;
               next_r.term_seen = 1'b0;
               next_r.done      = 1'b0;
            end
         end
         CCS_CC: begin
            next_r.code = CCS_ST_CC;
            if (r.cmp.at_term) begin
               next_r.st        = CCS_CV;
               next_r.term_seen = 1'b1;
            end else if (fast_exp) begin
               next_r.st = CCS_FAULT;
            end
         end
         CCS_CV: begin
            next_r.code = CCS_ST_CV;
            if (end_exp) begin
               next_r.st   = CCS_DONE;
               next_r.done = 1'b1;
            end else if (fast_exp) begin
               next_r.st = CCS_DONE;
            end
         end
         CCS_DONE: begin
            next_r.code = CCS_ST_DONE;
            // Recharge enters constant voltage
            if (r.cmp.below_rch && cfg_i.recharge_en && en_eff) begin
               next_r.st   = CCS_CV;
               next_r.done = 1'b0;
            end
         end
         CCS_STOP: begin
            next_r.code = CCS_ST_OFF;
            if (!en_eff) begin
               next_r.st = CCS_IDLE;
            end
         end
         CCS_FAULT: begin
            next_r.code = CCS_ST_FAULT;
            if (cfg_i.fault_clear || !r.cmp.supply_ok) begin
               next_r.st = CCS_IDLE;
            end
         end
         default: begin
            next_r.st = CCS_IDLE;
         end
      endcase

      // Safety expiry stops charging
      if (safe_exp && charging) begin
         next_r.st       = CCS_STOP;
         next_r.code     = CCS_ST_OFF;
         next_r.safe_run = 1'b0;
      end
      // Charging bit cleared stops charging only
      if (!en_eff && charging) begin
         next_r.st = CCS_IDLE;
      end
      // Chip disable stops charging and timers; the regulator follows the pin only
      if (!chip_on) begin
         next_r.st       = CCS_IDLE;
         next_r.code     = CCS_ST_OFF;
         next_r.wd_run   = 1'b0;
         next_r.safe_run = 1'b0;
      end

      // System power grant modes
      next_r.iso_off = 1'b0;
      case (cfg_i.grant_mode)
         CCS_SG_LDO: next_r.grant = chip_on && r.cmp.sys_ok;
         CCS_SG_BAT: next_r.grant = charging && r.cmp.above_weak;
         CCS_SG_MON: begin
            next_r.grant   = !r.cmp.supply_ok && cfg_i.battery_monitor_on
                             && !r.cmp.above_weak;
            next_r.iso_off = next_r.grant;
         end
         CCS_SG_MIX: begin
            next_r.grant = en_eff ? (charging && r.cmp.above_weak) : chip_on;
         end
         default: next_r.grant = 1'b0;
      endcase

      // Lamp patterns on the millisecond tick
      if (r.tick) begin
         if (r.lamp_ms >= 11'(CCS_SLOW_ON_MS + CCS_SLOW_OFF_MS - 1)) begin
            next_r.lamp_ms = '0;
         end else begin
            next_r.lamp_ms = r.lamp_ms + 11'h001;
         end
      end
      case (cfg_i.lamp_mode)
         CCS_LP_OFF:   next_r.lamp = 1'b0;
         CCS_LP_ON:    next_r.lamp = 1'b1;
         CCS_LP_SHORT: begin
            next_r.lamp = (r.lamp_ms % 11'(CCS_BLINK_ON_MS + CCS_BLINK_OFF_MS))
                          < 11'(CCS_BLINK_ON_MS);
         end
         CCS_LP_SLOW:  next_r.lamp = r.lamp_ms < 11'(CCS_SLOW_ON_MS);
         default:      next_r.lamp = 1'b0;
      endcase
      if (!chip_on) begin
         next_r.lamp  = 1'b0;
         next_r.grant = 1'b0;
      end

      // Copies taken from the final next state, so pins come from flops
      next_r.chg    = (next_r.st == CCS_CC) || (next_r.st == CCS_CV);
      next_r.cv     = next_r.st == CCS_CV;
      // Regulator stays up while only charging is off
      next_r.reg_on = !next_r.pins[0] && next_r.cmp.supply_ok;
      // Regulator output voltage choice
      next_r.sysv   = cfg_i.sysv_sel;
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         // Idle and default cap spelled out, though both are zero codes
         r      <= '0;
         r.st   <= CCS_IDLE;
         r.cap  <= CCS_CAP_DEFAULT;
      end else begin
         r <= next_r;
      end
   end

   // Outputs, all from flip-flops
   assign charge_on_o             = r.chg;
   assign cv_mode_o               = r.cv;
   assign regulator_on_o          = r.reg_on;
   assign sysv_sel_o              = r.sysv;
   assign input_current_cap_o     = r.cap;
   assign iso_switch_off_o        = r.iso_off;
   assign charge_state_o          = r.code;
   assign charge_done_flag_o      = r.done;
   assign recharge_needed_o       = r.rch_need;
   assign holdoff_en_o            = r.holdoff;
   // Open-drain data stays low; the enables carry the level
   assign system_power_grant_o    = 1'b0;
   assign system_power_grant_oe_o = r.grant;
   assign indicator_lamp_out_o    = 1'b0;
   assign indicator_lamp_out_oe_o = r.lamp;
endmodule

// file: design/ccs_timer.sv
// Tick-driven timer: counts slow ticks while running, pulses on limit
module ccs_timer import ccs_pkg::*; #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   // Control
   input  wire logic         tick_i,
   input  wire logic         run_i,
   input  wire logic         clr_i,
   input  wire logic [W-1:0] limit_i,
   // Result
   output logic              expired_o
);
   // Count and expiry, held as one state word
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         exp;
   } ccs_tmr_s;

   ccs_tmr_s r;        // Registered state
   ccs_tmr_s next_r;   // Next state

   // Count only on ticks; clear wins over counting
   always_comb begin
      next_r = r;
      next_r.exp = 1'b0;
      if (clr_i || !run_i) begin
         next_r.cnt = '0;
      end else if (tick_i) begin
         if (r.cnt + 1'b1 >= limit_i) begin
            next_r.cnt = '0;
            next_r.exp = 1'b1;
         end else begin
            next_r.cnt = r.cnt + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired_o = r.exp;
endmodule

// file: verification/ccs_cell_model.sv
module ccs_cell_model import ccs_pkg::*; (
   // Clock
   input  wire logic     mclk_i,
   // Charger controls seen by the cell
   input  wire logic     charge_on_i,
   input  wire logic     cv_mode_i,
   // Bench knobs: dead cell, held current, fixed levels
   input  wire logic     stuck_i,
   input  wire logic     hold_i,
   input  wire ccs_cmp_s base_i,
   // Comparator levels back to the charger
   output ccs_cmp_s      cmp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] volt = '0;    // Cell level, full at 16
   logic [3:0] amps = 4'hf;  // Taper current in CV
   // A stuck cell never climbs, so fast charge must time out
   always @(posedge mclk_i) begin
      if (stuck_i) volt <= '0;
      else if (charge_on_i && !volt[4]) volt <= volt + 5'h1;
      // Held current models a load that stops the taper
      if (hold_i || !cv_mode_i) amps <= 4'hf;
      else if (amps != 4'h0) amps <= amps - 4'h1;
   end
   // Termination and end-current comparators
   always_comb begin
      cmp_o = base_i;
      cmp_o.at_term = base_i.at_term | volt[4];
      cmp_o.below_end = cv_mode_i && !hold_i && (amps == 4'h0);
   end
endmodule

// file: verification/ccs_seq_assertions.sv
module ccs_seq_assertions import ccs_pkg::*; (
   // Clock and reset
   input wire logic       mclk_i,
   input wire logic       srst_i,
   // Inputs of the sequencer
   input wire ccs_cmp_s   cmp_i,
   input wire logic       option_pin_two_i,
   input wire logic       option_pin_three_i,
   input wire ccs_cfg_s   cfg_i,
   // Charger controls
   input wire logic       charge_on_o,
   input wire logic       cv_mode_o,
   input wire logic       regulator_on_o,
   input wire logic       sysv_sel_o,
   input wire logic [3:0] input_current_cap_o,
   input wire logic       iso_switch_off_o,
   // Status
   input wire logic [2:0] charge_state_o,
   input wire logic       charge_done_flag_o,
   input wire logic       recharge_needed_o,
   input wire logic       holdoff_en_o,
   // Open-drain pins
   input wire logic       system_power_grant_o,
   input wire logic       system_power_grant_oe_o,
   input wire logic       indicator_lamp_out_o,
   input wire logic       indicator_lamp_out_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so one clock and one disable for all
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // State code lags the control decode by one cycle
   chk_cc_code: assert property ($rose(charge_on_o) && !cv_mode_o |=>
      charge_state_o == CCS_ST_CC) else $error("CC start without code 010");
   chk_cv_code: assert property (cv_mode_o && charge_on_o ##1 cv_mode_o && charge_on_o
      |-> charge_state_o == CCS_ST_CV) else $error("CV without code 011");
   chk_fault_stop: assert property (charge_state_o == CCS_ST_FAULT |-> !charge_on_o)
      else $error("Charging during fault");
   chk_done_stop: assert property ($rose(charge_done_flag_o) |->
      !charge_on_o ##[0:1] charge_state_o == CCS_ST_DONE) else $error("Done flag wrong");
   // Pin needs three cycles to pass its synchroniser
   chk_chip_pin: assert property (option_pin_two_i [*4] |->
      !charge_on_o && !regulator_on_o) else $error("Chip disable ignored");
   chk_allow_clear: assert property (cfg_i.charging_allowed_wr && !cfg_i.charging_allowed
      |-> ##3 !charge_on_o) else $error("Charging bit clear ignored");
   chk_reset_vals: assert property ($fell(srst_i) |-> !holdoff_en_o &&
      input_current_cap_o == CCS_CAP_DEFAULT) else $error("Bad reset values");
   chk_hold_block: assert property ((holdoff_en_o && cmp_i.above_holdoff && !charge_on_o)
      [*4] |=> !charge_on_o) else $error("Start above hold-off level");
   chk_lamp_on: assert property ((cfg_i.lamp_mode == CCS_LP_ON && cfg_i.chip_en
      && !option_pin_two_i) [*4] |-> indicator_lamp_out_oe_o) else $error("Lamp not on");
   chk_lamp_off: assert property (cfg_i.lamp_mode == CCS_LP_OFF [*3] |->
      !indicator_lamp_out_oe_o) else $error("Lamp not off");
   chk_pin_data: assert property (!system_power_grant_o && !indicator_lamp_out_o)
      else $error("Open-drain data not low");
   // Main scenarios reached
   cover property ($rose(charge_done_flag_o));
   cover property (charge_state_o == CCS_ST_FAULT);
   cover property ($rose(recharge_needed_o));
endmodule

bind ccs_sequencer ccs_seq_assertions chk_u (.mclk_i, .srst_i, .cmp_i, .option_pin_two_i,
   .option_pin_three_i, .cfg_i, .charge_on_o, .cv_mode_o, .regulator_on_o, .sysv_sel_o,
   .input_current_cap_o, .iso_switch_off_o, .charge_state_o, .charge_done_flag_o,
   .recharge_needed_o, .holdoff_en_o, .system_power_grant_o, .system_power_grant_oe_o,
   .indicator_lamp_out_o, .indicator_lamp_out_oe_o);

// file: verification/testbench.sv
module testbench import ccs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;  // Cycles per slow tick, short for sim
   logic       mclk_i, srst_i, option_pin_two_i, option_pin_three_i;
   logic       stuck, hold, kick_en;  // Bench knobs
   ccs_cmp_s   cmp_i, cmp_base;
   ccs_cfg_s   cfg_i;
   logic       charge_on_o, cv_mode_o, regulator_on_o, sysv_sel_o, iso_switch_off_o;
   logic [3:0] input_current_cap_o;
   logic [2:0] charge_state_o;
   logic       charge_done_flag_o, recharge_needed_o, holdoff_en_o;
   logic       system_power_grant_o, system_power_grant_oe_o;
   logic       indicator_lamp_out_o, indicator_lamp_out_oe_o;
   int         mismatches, checks, cyc, n, i;
   int         lamp_on[4] = '{0, 8000, 1336, 4000};  // Lamp-on cycles per 8000
   ccs_sequencer #(.FAST_MS(60), .WDOG_MS(20), .SAFE_MS(20), .END_MS(10), .TICK_CYC(TK)) dut_u (
      .mclk_i, .srst_i, .cmp_i, .option_pin_two_i, .option_pin_three_i, .cfg_i,
      .charge_on_o, .cv_mode_o, .regulator_on_o, .sysv_sel_o, .input_current_cap_o,
      .iso_switch_off_o, .charge_state_o, .charge_done_flag_o, .recharge_needed_o,
      .holdoff_en_o, .system_power_grant_o, .system_power_grant_oe_o,
      .indicator_lamp_out_o, .indicator_lamp_out_oe_o);
   ccs_cell_model cell_u (.mclk_i, .charge_on_i(charge_on_o), .cv_mode_i(cv_mode_o),
      .stuck_i(stuck), .hold_i(hold), .base_i(cmp_base), .cmp_o(cmp_i));
   // 100 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Host kicks well inside the watchdog period; hang guard
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      cfg_i.watchdog_kick <= kick_en && (cyc % 20 == 0);
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Host write of the charging bit, one-cycle strobe
   task automatic allow(input logic v);
      cfg_i.charging_allowed <= v;
      cfg_i.charging_allowed_wr <= 1'b1;
      tick(1);
      cfg_i.charging_allowed_wr <= 1'b0;
   endtask
   // Bounded wait for a charge state code
   task automatic wait_st(input logic [2:0] code);
      for (n = 0; n < 600 && charge_state_o !== code; n++) tick(1);
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      cfg_i = '0;
      cfg_i.chip_en = 1'b1;
      cfg_i.recharge_en = 1'b1;
      cmp_base = '0;
      cmp_base.above_dead = 1'b1;
      cmp_base.above_weak = 1'b1;
      cmp_base.supply_ok = 1'b1;
      cmp_base.sys_ok = 1'b1;
      srst_i = 1'b1;
      option_pin_two_i = 1'b0;
      option_pin_three_i = 1'b1;
      {stuck, hold, kick_en} = 3'h1;
      tick(5);
      check(holdoff_en_o, 1'b0);
      check(input_current_cap_o, CCS_CAP_DEFAULT);
      srst_i <= 1'b0;
      // Pin enable alone starts a full cycle
      wait_st(CCS_ST_CC);
      check(charge_on_o, 1'b1);
      wait_st(CCS_ST_CV);
      check(cv_mode_o, 1'b1);
      wait_st(CCS_ST_DONE);
      check(charge_done_flag_o, 1'b1);
      // Recharge goes straight to CV; a late current bump restarts qualify
      cmp_base.below_rch <= 1'b1;
      wait_st(CCS_ST_CV);
      check(charge_state_o, CCS_ST_CV);
      cmp_base.below_rch <= 1'b0;
      tick(46);
      hold <= 1'b1;
      tick(2);
      hold <= 1'b0;
      wait_st(CCS_ST_DONE);
      check(n >= 48, 1'b1);
      $display("Test charge cycle finished");
      // Host clear beats the pin; regulator stays up
      allow(1'b0);
      cmp_base.below_rch <= 1'b1;
      cfg_i.sysv_sel <= 1'b1;
      tick(6);
      check(charge_on_o, 1'b0);
      check(regulator_on_o, 1'b1);
      check(sysv_sel_o, 1'b1);
      cmp_base.below_rch <= 1'b0;
      // Chip off by register, then start blocked by hold-off
      cfg_i.chip_en <= 1'b0;
      stuck <= 1'b1;
      cfg_i.high_battery_holdoff_en <= 1'b1;
      cmp_base.above_holdoff <= 1'b1;
      tick(4);
      check(charge_on_o, 1'b0);
      check(system_power_grant_oe_o, 1'b0);
      cfg_i.chip_en <= 1'b1;
      allow(1'b1);
      tick(20);
      check(charge_on_o, 1'b0);
      check(holdoff_en_o, 1'b1);
      cmp_base.above_holdoff <= 1'b0;
      wait_st(CCS_ST_CC);
      check(charge_state_o, CCS_ST_CC);
      // Dead cell: fast charge times out into fault, host clears it
      wait_st(CCS_ST_FAULT);
      check(charge_on_o, 1'b0);
      {stuck, hold} <= 2'h1;
      cfg_i.fault_clear <= 1'b1;
      tick(1);
      cfg_i.fault_clear <= 1'b0;
      tick(4);
      check(charge_state_o !== CCS_ST_FAULT, 1'b1);
      // Timeout in CV before end current: stop without flag
      wait_st(CCS_ST_DONE);
      check(charge_done_flag_o, 1'b0);
      hold <= 1'b0;
      cmp_base.below_rch <= 1'b1;
      wait_st(CCS_ST_CV);
      check(charge_on_o, 1'b1);
      cmp_base.below_rch <= 1'b0;
      wait_st(CCS_ST_DONE);
      // Recharge off still flags the host
      cfg_i.recharge_en <= 1'b0;
      cmp_base.below_rch <= 1'b1;
      tick(6);
      check(recharge_needed_o, 1'b1);
      check(charge_on_o, 1'b0);
      $display("Test faults and enables finished");
      // Kicks stop: watchdog expiry restores cap, safety ends charge
      {kick_en, hold} <= 2'h1;
      cfg_i.cap_value <= 4'h5;
      cfg_i.cap_wr <= 1'b1;
      tick(1);
      cfg_i.cap_wr <= 1'b0;
      cfg_i.recharge_en <= 1'b1;
      tick(3);
      check(input_current_cap_o, 4'h5);
      for (n = 0; n < 200 && input_current_cap_o !== CCS_CAP_DEFAULT; n++) tick(1);
      check(charge_on_o, 1'b1);
      for (n = 0; n < 200 && charge_on_o === 1'b1; n++) tick(1);
      check(n >= 72 && n < 200, 1'b1);
      {kick_en, hold} <= 2'h2;
      $display("Test watchdog finished");
      // Lamp patterns over one whole 2000 ms counter period each
      for (i = 0; i < 4; i++) begin
         cfg_i.lamp_mode <= i[1:0];
         tick(8);
         n = 0;
         repeat (8000) begin
            tick(1);
            if (indicator_lamp_out_oe_o === 1'b1) n++;
         end
         check(n, lamp_on[i]);
      end
      // Grant modes, then chip off by pin
      cfg_i.grant_mode <= CCS_SG_LDO;
      tick(6);
      check(system_power_grant_oe_o, 1'b1);
      cfg_i.battery_monitor_on <= 1'b1;
      cfg_i.grant_mode <= CCS_SG_MON;
      cmp_base.supply_ok <= 1'b0;
      cmp_base.above_weak <= 1'b0;
      tick(6);
      check({iso_switch_off_o, system_power_grant_oe_o}, 2'h3);
      option_pin_two_i <= 1'b1;
      tick(6);
      check(system_power_grant_oe_o, 1'b0);
      cmp_base.supply_ok <= 1'b1;
      tick(6);
      check(regulator_on_o, 1'b0);
      $display("Test outputs finished");
      end_sim();
   end
endmodule
